// ---- inc/array_config_port_map.vh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef ARRAY_CONFIG_PORT_MAP_VH
`define ARRAY_CONFIG_PORT_MAP_VH
`define CFG_OFS_CTRL 12'h000
`define CFG_OFS_BASE 12'h004
`define CFG_OFS_LEN 12'h008
`define CFG_OFS_STATUS 12'h00C
`define CFG_OFS_PTR 12'h010
`define CFG_RAM_WIN 2'h1
`define CFG_CTRL_VERIFY 0
`define CFG_CTRL_ERROR 1
`define CFG_CTRL_CASCADE 2
`define CFG_CTRL_RESET 3'h7
`define CFG_BASE_RESET 11'h000
`define CFG_LEN_RESET 12'h100
`define CFG_ST_INIT_DONE 0
`define CFG_ST_ACTIVE 1
`define CFG_ST_ERROR 2
`define CFG_ST_MISMATCH 3
`define CFG_ST_FILE_ERR 4
`define CFG_ST_DONE 5
`define CFG_ST_MODE_LSB 8
`define CFG_PREAMBLE 8'hB7
`define CFG_RAM_DEPTH 256
`define CFG_PCLK_NS 50
`define CFG_INIT_TIME_NS 1000
`define CFG_INIT_CYCLES ((`CFG_INIT_TIME_NS + `CFG_PCLK_NS - 1) / `CFG_PCLK_NS)
`define CFG_CONFIG_CLOCK_HALF_NS 500
`define CFG_CONFIG_CLOCK_HALF_CYCLES (`CFG_CONFIG_CLOCK_HALF_NS / `CFG_PCLK_NS)
`define CFG_MODE_P1 3'h1
`define CFG_MODE_P2 3'h2
`define CFG_MODE_S3 3'h3
`define CFG_MODE_S4 3'h4
`define CFG_MODE_P5 3'h5
`define CFG_MODE_P6 3'h6
`endif

// ---- rtl/array_config_port.v ----
// Configuration loader port of a cell-based logic array, with APB access.
`timescale 1ns/1ns
`include "array_config_port_map.vh"

// Notes on behaviour
// [RULE_01] Hold config_in_progress low during power-up init, then release it.
// [RULE_02] After init, an external low on config_in_progress starts loading.
// [RULE_03] Configuration pins are ignored while config_select_n is high.
// [RULE_04] The loader keeps config_select_n low throughout a configuration; the code only reads it and drops to ST_IDLE if it goes high.
// [RULE_05] The three mode_select pins pick the configuration mode.
// [RULE_06] config_clock is input in modes 1,2,3,6; driven near 1 MHz in 4,5.
// [RULE_07] Inputs sampled and outputs changed on config_clock rising edges.
// [RULE_08] Array registers run on the array clock, apart from configuration.
// [RULE_09] Array reset is asynchronous and independent of configuration.
// [RULE_10] Shared pins are user I/O while config_in_progress is high.
// [RULE_11] Serial modes take bit on data 0; parallel take whole byte.
// [RULE_12] Modes 1, 2 and 5 drive config_address to an external memory.
// [RULE_13] config_address changes only after a config_clock rising edge.
// [RULE_14] cascade_select_out enables the next device; it may be disabled.
// [RULE_15] Verify compares, never writes; mismatch pulls config_error low.
// [RULE_16] config_error is registered and sticks until the next start.
// [RULE_17] Configuration file errors also assert config_error.
// [RULE_18] Verify and error reporting can both be switched off.
// [RULE_19] At power-up every user pin is an input with pull-up.
// [RULE_20] Partial reconfiguration rewrites a region; the rest keeps working.
// [RULE_21] Each pin pairs exit and entrance cells; A and B types alternate.
// [RULE_22] Each accepted bit or byte goes to the next configuration location.
module array_config_port (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire config_in_progress_n_i,
   output wire config_in_progress_n_o,
   output wire config_in_progress_n_oe_n,
   input wire config_select_n,
   input wire [2:0] mode_select,
   input wire config_clock_i,
   output wire config_clock_o,
   output wire config_clock_oe_n,
   input wire config_data_0,
   input wire [6:0] config_data_1_7,
   input wire verify_enable_n,
   output wire config_error_n,
   output wire config_error_oe_n,
   output wire [16:0] config_address,
   output wire config_address_oe_n,
   output wire cascade_select_out_n,
   output wire cascade_select_oe_n,
   output wire [7:0] user_out,
   output wire [7:0] user_oe_n,
   output wire [7:0] user_pullup,
   input wire array_clock,
   input wire array_reset_n,
   output wire [7:0] array_state
);

   localparam ST_INIT = 2'h0;
   localparam ST_IDLE = 2'h1;
   localparam ST_LOAD = 2'h2;
   localparam ST_DONE = 2'h3;
   localparam integer INIT_CYC_I = `CFG_INIT_CYCLES;
   localparam integer HALF_CYC_I = `CFG_CONFIG_CLOCK_HALF_CYCLES;
   localparam integer SER_LAST_I = (`CFG_RAM_DEPTH * 8) - 1;
   localparam integer PAR_LAST_I = `CFG_RAM_DEPTH - 1;
   localparam [7:0] INIT_CYC = INIT_CYC_I[7:0];
   localparam [3:0] HALF_CYC = HALF_CYC_I[3:0];
   localparam [10:0] SER_LAST = SER_LAST_I[10:0];
   localparam [10:0] PAR_LAST = PAR_LAST_I[10:0];

   reg [7:0] mem [0:`CFG_RAM_DEPTH-1];
   reg [14:0] in_s1_r;
   reg [14:0] in_s2_r;
   reg config_clock_d_r;
   reg [1:0] state_r;
   reg [7:0] init_cnt_r;
   reg [2:0] mode_r;
   reg verify_r;
   reg hdr_wait_r;
   reg [2:0] hdr_cnt_r;
   reg [6:0] hdr_sh_r;
   reg [10:0] ptr_r;
   reg [11:0] cnt_r;
   reg [16:0] addr_r;
   reg mismatch_r;
   reg ferr_r;
   reg casc_r;
   reg [3:0] div_cnt_r;
   reg int_clk_r;
   reg int_rise_r;
   reg [2:0] ctrl_r;
   reg [10:0] base_r;
   reg [11:0] len_r;
   reg [7:0] array_state_r;
   reg err_r;
   integer i;

   // Every configuration pin passes two flops before the loader uses it.
   wire con_s = in_s2_r[14];
   wire cs_n_s = in_s2_r[13];
   wire [2:0] mode_s = in_s2_r[12:10];
   wire config_clock_s = in_s2_r[9];
   wire [7:0] data_s = in_s2_r[8:1];
   wire verify_n_s = in_s2_r[0];

   wire serial = (mode_r == `CFG_MODE_S3) || (mode_r == `CFG_MODE_S4);
   wire int_mode = (mode_r == `CFG_MODE_S4) || (mode_r == `CFG_MODE_P5);
   wire addr_mode = (mode_r == `CFG_MODE_P1) || (mode_r == `CFG_MODE_P2) ||
      (mode_r == `CFG_MODE_P5);
   wire mode_ok = (mode_s != 3'h0) && (mode_s != 3'h7);
   wire loading = (state_r == ST_LOAD) || (state_r == ST_DONE);
   wire cfg_pins = ~con_s;
   wire active = (state_r != ST_INIT) && ~con_s && ~cs_n_s;
   wire ext_rise = config_clock_s & ~config_clock_d_r;
   wire config_clock_edge = int_mode ? int_rise_r : ext_rise;
   wire accept = (state_r == ST_LOAD) && active && config_clock_edge;
   wire err_any = mismatch_r | ferr_r;
   wire [7:0] cur_byte = mem[ptr_r[7:0]];
   wire cur_bit = mem[ptr_r[10:3]][ptr_r[2:0]];
   wire [7:0] hdr_byte = {data_s[0], hdr_sh_r};
   wire last_loc = serial ? (ptr_r == SER_LAST) : (ptr_r == PAR_LAST);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_s1_r <= 15'h7FFF;
         in_s2_r <= 15'h7FFF;
         config_clock_d_r <= 1'b1;
      end else begin
         in_s1_r <= {config_in_progress_n_i, config_select_n, mode_select,
            config_clock_i, config_data_1_7, config_data_0,
            verify_enable_n};
         in_s2_r <= in_s1_r;
         config_clock_d_r <= config_clock_s;
      end
   end

   // Internal configuration clock for the self-clocked modes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 4'h0;
         int_clk_r <= 1'b0;
         int_rise_r <= 1'b0;
      end else if (int_mode && loading) begin
         int_rise_r <= 1'b0;
         if (div_cnt_r == HALF_CYC - 4'h1) begin
            div_cnt_r <= 4'h0;
            int_clk_r <= ~int_clk_r;
            int_rise_r <= ~int_clk_r;
         end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
         end
      end else begin
         div_cnt_r <= 4'h0;
         int_clk_r <= 1'b0;
         int_rise_r <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_INIT;
         init_cnt_r <= 8'h00;
         mode_r <= 3'h0;
         verify_r <= 1'b0;
         hdr_wait_r <= 1'b0;
         hdr_cnt_r <= 3'h0;
         hdr_sh_r <= 7'h00;
         ptr_r <= 11'h000;
         cnt_r <= 12'h000;
         addr_r <= 17'h00000;
         mismatch_r <= 1'b0;
         ferr_r <= 1'b0;
         casc_r <= 1'b0;
         // Cleared memory leaves every user pin an input with pull-up.
         for (i = 0; i < `CFG_RAM_DEPTH; i = i + 1) begin
            mem[i] <= 8'h00; // RULE_19
         end
      end else begin
         case (state_r)
            ST_INIT: begin
               if (init_cnt_r == INIT_CYC - 8'h01) begin
                  state_r <= ST_IDLE; // RULE_01
               end else begin
                  init_cnt_r <= init_cnt_r + 8'h01;
               end
            end
            ST_IDLE: begin
               if (active) begin // RULE_02 RULE_03
                  state_r <= ST_LOAD;
                  mode_r <= mode_s; // RULE_05
                  verify_r <= ~verify_n_s & ctrl_r[`CFG_CTRL_VERIFY]; // RULE_18
                  hdr_wait_r <= 1'b1;
                  hdr_cnt_r <= 3'h0;
                  ptr_r <= base_r; // RULE_20
                  cnt_r <= 12'h000;
                  addr_r <= 17'h00000;
                  mismatch_r <= 1'b0; // RULE_16
                  ferr_r <= ~mode_ok; // RULE_17
                  casc_r <= 1'b0;
               end
            end
            ST_LOAD: begin
               if (!active) begin
                  state_r <= ST_IDLE; // RULE_04
               end else if (accept) begin // RULE_07
                  if (addr_mode) begin
                     addr_r <= addr_r + 17'h00001; // RULE_12 RULE_13
                  end
                  if (hdr_wait_r) begin
                     // The leading preamble is checked and never stored.
                     if (!serial) begin
                        hdr_wait_r <= 1'b0;
                        if (data_s != `CFG_PREAMBLE) begin
                           ferr_r <= 1'b1; // RULE_17
                        end
                     end else if (hdr_cnt_r == 3'h7) begin
                        hdr_wait_r <= 1'b0;
                        if (hdr_byte != `CFG_PREAMBLE) begin
                           ferr_r <= 1'b1; // RULE_17
                        end
                     end else begin
                        hdr_cnt_r <= hdr_cnt_r + 3'h1;
                        hdr_sh_r <= {data_s[0], hdr_sh_r[6:1]};
                     end
                  end else begin
                     if (verify_r) begin
                        if (serial ? (cur_bit != data_s[0])
                           : (cur_byte != data_s)) begin
                           mismatch_r <= 1'b1; // RULE_15
                        end
                     end else if (serial) begin
                        mem[ptr_r[10:3]][ptr_r[2:0]] <= data_s[0]; // RULE_11
                     end else begin
                        mem[ptr_r[7:0]] <= data_s; // RULE_11
                     end
                     // Reaching the last location of memory is a file fault.
                     if (last_loc) begin
                        ferr_r <= 1'b1; // RULE_17
                     end else begin
                        ptr_r <= ptr_r + 11'h001; // RULE_22
                     end
                     cnt_r <= cnt_r + 12'h001;
                     if (cnt_r + 12'h001 == len_r) begin
                        state_r <= ST_DONE;
                        casc_r <= 1'b1; // RULE_14
                     end
                  end
               end
            end
            ST_DONE: begin
               if (!active) begin
                  state_r <= ST_IDLE;
                  casc_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_INIT;
            end
         endcase
      end
   end

   // The device only ever pulls this line low; the board supplies the high.
   assign config_in_progress_n_o = 1'b0;
   assign config_in_progress_n_oe_n = (state_r != ST_INIT); // RULE_01

   assign config_clock_o = int_clk_r;
   assign config_clock_oe_n = ~(int_mode && loading); // RULE_06

   assign config_address = addr_r;
   assign config_address_oe_n = ~(cfg_pins && addr_mode && loading); // RULE_12

   // The error pin comes from one flop, so it cannot glitch when both error
   // sources change together; it trails the status bit by one cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r <= 1'b0;
      end else begin
         err_r <= err_any; // RULE_16
      end
   end
   assign config_error_n = ~err_r; // RULE_15
   assign config_error_oe_n = ~(cfg_pins && ctrl_r[`CFG_CTRL_ERROR]); // RULE_18

   assign cascade_select_out_n = ~casc_r;
   assign cascade_select_oe_n = ~ctrl_r[`CFG_CTRL_CASCADE]; // RULE_14

   // Array registers run purely on the array clock and reset pins, but they load
   // config_data_0 and config_data_1_7, so a reconfiguration changes what they capture.
   always @(posedge array_clock or negedge array_reset_n) begin
      if (!array_reset_n) begin
         array_state_r <= 8'h00; // RULE_09
      end else begin
         array_state_r <= {config_data_1_7, config_data_0}; // RULE_08
      end
   end
   assign array_state = array_state_r;

   // Location 0 holds pin directions, location 1 the B-type exit values.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : pin
         if (g % 2 == 0) begin : a_type
            assign user_out[g] = array_state_r[g]; // RULE_21
         end else begin : b_type
            assign user_out[g] = mem[1][g]; // RULE_21
         end
         assign user_oe_n[g] = cfg_pins | ~mem[0][g]; // RULE_10
         assign user_pullup[g] = user_oe_n[g]; // RULE_19
      end
   endgenerate

   // APB slave: zero wait states, errors for unmapped or read-only writes.
   wire ram_hit = (paddr[11:10] == `CFG_RAM_WIN);
   wire reg_hit = (paddr == `CFG_OFS_CTRL) || (paddr == `CFG_OFS_BASE) ||
      (paddr == `CFG_OFS_LEN) || (paddr == `CFG_OFS_STATUS) ||
      (paddr == `CFG_OFS_PTR);
   wire ro_hit = ram_hit || (paddr == `CFG_OFS_STATUS) ||
      (paddr == `CFG_OFS_PTR);
   wire bad = ~(reg_hit | ram_hit) | (pwrite & ro_hit);
   wire wr_ok = psel & penable & pwrite & ~bad;

   assign pready = 1'b1;
   assign pslverr = psel & penable & bad;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `CFG_CTRL_RESET;
         base_r <= `CFG_BASE_RESET;
         len_r <= `CFG_LEN_RESET;
      end else if (wr_ok) begin
         if (paddr == `CFG_OFS_CTRL) begin
            ctrl_r <= pwdata[2:0];
         end
         if (paddr == `CFG_OFS_BASE) begin
            base_r <= pwdata[10:0]; // RULE_20
         end
         if (paddr == `CFG_OFS_LEN) begin
            len_r <= pwdata[11:0];
         end
      end
   end

   always @* begin
      prdata = 32'h00000000;
      if (ram_hit) begin
         prdata = {24'h000000, mem[paddr[9:2]]};
      end else begin
         case (paddr)
            `CFG_OFS_CTRL: prdata = {29'h00000000, ctrl_r};
            `CFG_OFS_BASE: prdata = {21'h000000, base_r};
            `CFG_OFS_LEN: prdata = {20'h00000, len_r};
            `CFG_OFS_STATUS: begin
               prdata[`CFG_ST_INIT_DONE] = (state_r != ST_INIT);
               prdata[`CFG_ST_ACTIVE] = loading;
               prdata[`CFG_ST_ERROR] = err_any;
               prdata[`CFG_ST_MISMATCH] = mismatch_r;
               prdata[`CFG_ST_FILE_ERR] = ferr_r;
               prdata[`CFG_ST_DONE] = (state_r == ST_DONE);
               prdata[`CFG_ST_MODE_LSB+2:`CFG_ST_MODE_LSB] = mode_r;
            end
            `CFG_OFS_PTR: prdata = {9'h000, cnt_r, ptr_r};
            default: prdata = 32'h00000000;
         endcase
      end
   end

endmodule

// ---- tb/array_config_port_chk.sv ----
// Concurrent checks on the configuration pins of the port.
`timescale 1ns/1ns
module array_config_port_chk (
   input wire pclk,
   input wire presetn,
   input wire config_in_progress_n_i,
   input wire config_in_progress_n_oe_n,
   input wire config_select_n,
   input wire [2:0] mode_select,
   input wire config_clock_i,
   input wire config_clock_o,
   input wire config_clock_oe_n,
   input wire config_error_n,
   input wire [16:0] config_address,
   input wire config_address_oe_n,
   input wire [7:0] user_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg [5:0] up_r;
   reg [3:0] rise_r;
   reg config_clock_r;
   wire config_clock = config_clock_oe_n ? config_clock_i : config_clock_o;
   wire pmode = mode_select == 3'h1 || mode_select == 3'h2 ||
      mode_select == 3'h5;
   wire dmode = mode_select == 3'h4 || mode_select == 3'h5;
   // Cycles since reset release and since the last link clock rise.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_r <= 6'h00;
         rise_r <= 4'hF;
         config_clock_r <= 1'b0;
      end else begin
         config_clock_r <= config_clock;
         if (up_r != 6'h3F) up_r <= up_r + 6'h01;
         if (config_clock && !config_clock_r) rise_r <= 4'h0;
         else if (rise_r != 4'hF) rise_r <= rise_r + 4'h1;
      end
   end
   AST_INIT_HOLD: assert property (
      (up_r < 6'h12) |-> !config_in_progress_n_oe_n)
      else $error("line released during init");
   AST_INIT_FREE: assert property (
      (up_r > 6'h16) |-> config_in_progress_n_oe_n)
      else $error("line still pulled after init");
   AST_CS_IGNORE: assert property (
      config_select_n [*4] |-> $stable(config_address))
      else $error("address moved while deselected");
   AST_ADDR_AFTER_EDGE: assert property (
      ($changed(config_address) && config_address != 17'h00000)
      |-> rise_r < 4'h9)
      else $error("address moved without a clock rise");
   AST_ADDR_OE_MODE: assert property (
      !config_address_oe_n |-> pmode)
      else $error("address driven in wrong mode");
   AST_CONFIG_CLOCK_OE_MODE: assert property (
      !config_clock_oe_n |-> dmode)
      else $error("clock driven in wrong mode");
   AST_CONFIG_CLOCK_HIGH: assert property (
      $rose(config_clock_o) |-> (config_clock_o || config_clock_oe_n) [*8])
      else $error("driven clock high phase too short");
   AST_ERR_STICKY: assert property (
      $rose(config_error_n) |-> !$past(config_in_progress_n_i, 2))
      else $error("error cleared without a restart");
   AST_PINS_RELEASED: assert property (
      !config_in_progress_n_i [*4] |-> user_oe_n == 8'hFF)
      else $error("user pin driven during configuration");
endmodule

// ---- tb/array_config_port_tb_top.sv ----
// Self-checking bench for the configuration port.
`timescale 1ns/1ns
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, g, e); \
   end \
end
module array_config_port_tb_top;
   logic pclk, presetn, psel, penable, pwrite, er, con_low, run, ext, ser, ua;
   logic config_select_n, verify_enable_n, array_clock, array_reset_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [2:0] mode_select;
   wire [31:0] prdata;
   wire pready, pslverr, config_in_progress_n_o, config_in_progress_n_oe_n;
   wire config_clock_o, config_clock_oe_n, config_error_n, config_error_oe_n;
   wire config_address_oe_n, cascade_select_out_n, cascade_select_oe_n;
   wire mclk, config_clock_i, config_in_progress_n_i;
   wire [16:0] config_address;
   wire [7:0] user_out, user_oe_n, user_pullup, array_state, data;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   // Open-drain line with a pull-up: low while either party pulls it.
   assign config_in_progress_n_i =
      !((!config_in_progress_n_oe_n && !config_in_progress_n_o) || con_low);
   assign config_clock_i = config_clock_oe_n ? mclk : config_clock_o;
   array_config_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .config_in_progress_n_i,
      .config_in_progress_n_o, .config_in_progress_n_oe_n, .config_select_n,
      .mode_select, .config_clock_i, .config_clock_o, .config_clock_oe_n,
      .config_data_0(data[0]), .config_data_1_7(data[7:1]),
      .verify_enable_n, .config_error_n, .config_error_oe_n, .config_address,
      .config_address_oe_n, .cascade_select_out_n, .cascade_select_oe_n,
      .user_out, .user_oe_n, .user_pullup, .array_clock, .array_reset_n,
      .array_state);
   config_memory_model mem (.run, .ext, .serial(ser), .use_addr(ua),
      .config_clock(config_clock_i), .address(config_address), .clk_out(mclk), .data);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      array_clock = 1'b0;
      forever #130 array_clock = ~array_clock;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict;
      end
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task load(input logic [2:0] m);
      int n;
      n = 0;
      mode_select <= m;
      ser <= m == 3'h3 || m == 3'h4;
      ext <= !(m == 3'h4 || m == 3'h5);
      ua <= m == 3'h1 || m == 3'h2 || m == 3'h5;
      repeat (4) @(posedge pclk);
      con_low <= 1'b1;
      config_select_n <= 1'b0;
      repeat (5) @(posedge pclk);
      run <= 1'b1;
      @(posedge pclk);
      `CHK(config_clock_oe_n, ext)
      `CHK(config_address_oe_n, !ua)
      `CHK(user_oe_n, 8'hFF)
      `CHK(config_error_oe_n, 1'b0)
      `CHK(cascade_select_oe_n, 1'b0)
      while (cascade_select_out_n !== 1'b0 && config_error_n !== 1'b0 &&
         n < 3000) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n < 3000, 1'b1)
      `CHK(config_address, ua ? 17'h00003 : 17'h00000)
   endtask
   task stop;
      run <= 1'b0;
      con_low <= 1'b0;
      config_select_n <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   task check_ram(input logic [7:0] b0, input logic [7:0] b1);
      apb(1'b0, 12'h400, 32'h0);
      `CHK(rd[7:0], b0)
      apb(1'b0, 12'h404, 32'h0);
      `CHK(rd[7:0], b1)
   endtask
   initial begin
      {presetn, psel, penable, pwrite, con_low, run, ext, ser, ua} = 9'h000;
      {config_select_n, verify_enable_n, array_reset_n} = 3'h7;
      {paddr, pwdata, mode_select} = 47'h0;
      repeat (8) @(posedge pclk);
      `CHK(config_in_progress_n_oe_n, 1'b0)
      `CHK(user_oe_n, 8'hFF)
      `CHK(user_pullup, 8'hFF)
      presetn <= 1'b1;
      repeat (30) @(posedge pclk);
      `CHK(config_in_progress_n_i, 1'b1)
      apb(1'b0, 12'h000, 32'h0);
      `CHK(rd[2:0], 3'h7)
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd[11:0], 12'h100)
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK(er, 1'b1)
      apb(1'b1, 12'h00C, 32'h3F);
      `CHK(er, 1'b1)
      $display("reset and registers done");
      for (logic [2:0] m = 3'h1; m != 3'h7; m++) begin
         mem.rom[0] = 8'hB7;
         mem.rom[1] = {5'h06, m};
         mem.rom[2] = {5'h18, m};
         apb(1'b1, 12'h008, (m == 3'h3 || m == 3'h4) ? 32'h10 : 32'h2);
         load(m);
         `CHK(cascade_select_out_n, 1'b0)
         apb(1'b0, 12'h00C, 32'h0);
         `CHK({rd[10:8], rd[5], rd[2]}, {m, 2'h2})
         stop;
         `CHK(user_oe_n, ~mem.rom[1])
         check_ram(mem.rom[1], mem.rom[2]);
         $display("mode %0d load done", m);
      end
      verify_enable_n <= 1'b0;
      mem.rom[2] = 8'h00;
      load(3'h1);
      stop;
      `CHK(config_error_n, 1'b0)
      check_ram(8'h36, 8'hC6);
      verify_enable_n <= 1'b1;
      mem.rom[0] = 8'h00;
      load(3'h6);
      apb(1'b0, 12'h00C, 32'h0);
      `CHK(rd[4], 1'b1)
      stop;
      mem.rom[0] = 8'hB7;
      mem.rom[2] = 8'h5A;
      load(3'h2);
      `CHK(config_error_n, 1'b1)
      stop;
      check_ram(8'h36, 8'h5A);
      apb(1'b1, 12'h004, 32'h2);
      load(3'h6);
      stop;
      check_ram(8'h36, 8'h5A);
      apb(1'b0, 12'h408, 32'h0);
      `CHK(rd[7:0], 8'h36)
      apb(1'b0, 12'h010, 32'h0);
      `CHK(rd[22:0], {12'h002, 11'h004})
      $display("verify and error test done");
      apb(1'b1, 12'h000, 32'h5);
      con_low <= 1'b1;
      ext <= 1'b1;
      run <= 1'b1;
      repeat (60) @(posedge pclk);
      `CHK(config_error_oe_n, 1'b1)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK(rd[1], 1'b0)
      stop;
      check_ram(8'h36, 8'h5A);
      array_reset_n <= 1'b0;
      @(posedge pclk);
      `CHK(array_state, 8'h00)
      array_reset_n <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK(array_state, data)
      `CHK(user_out, (data & 8'h55) | 8'h0A)
      $display("deselect and array test done");
      print_verdict;
   end
endmodule
bind array_config_port array_config_port_chk chk (.pclk, .presetn,
   .config_in_progress_n_i, .config_in_progress_n_oe_n, .config_select_n,
   .mode_select, .config_clock_i, .config_clock_o, .config_clock_oe_n,
   .config_error_n, .config_address, .config_address_oe_n, .user_oe_n);

// ---- tb/config_memory_model.sv ----
// Configuration memory and link clock source facing the port.
`timescale 1ns/1ns
module config_memory_model (
   input wire logic run,
   input wire logic ext,
   input wire logic serial,
   input wire logic use_addr,
   input wire logic config_clock,
   input wire logic [16:0] address,
   output logic clk_out,
   output logic [7:0] data
);
   logic [7:0] rom [0:7];
   logic [7:0] cur;
   logic [7:0] last = 8'h00;
   logic [5:0] k;
   // The clock stands low between frames, so no stray rise is seen.
   initial begin
      clk_out = 1'b0;
      #7;
      forever #200 clk_out = run && ext ? ~clk_out : 1'b0;
   end
   // Data move on the falling edge, so they are settled at each rise.
   always @(negedge config_clock or negedge run) begin
      if (!run) k <= 6'h00;
      else k <= k + 6'h01;
   end
   always @* begin
      cur = rom[use_addr ? address[2:0] : (serial ? k[5:3] : k[2:0])];
      if (!run) data = ~last;
      else data = serial ? {7'h00, cur[k[2:0]]} : cur;
   end
   always @(negedge run) last = cur;
endmodule
